// file: verilog/ldr_defs.vh
`ifndef LDR_DEFS_VH
`define LDR_DEFS_VH
`define LDR_ADDR_CTL0 8'h65
`define LDR_ADDR_CTL1 8'h61
`define LDR_ADDR_CTL2 8'h66
`define LDR_ADDR_SEQ0 8'hed
`define LDR_ADDR_SEQ1 8'hee
`define LDR_ADDR_SEQ2 8'hef
`define LDR_ADDR_VOUT0 8'h68
`define LDR_ADDR_VOUT1 8'h69
`define LDR_ADDR_VOUT2 8'h6a
`define LDR_CTL_RESET 8'h00
`define LDR_CTL_MASK 8'h03
`define LDR_SEQ_MASK 8'h3f
`define LDR_VOUT_MASK 8'h1f
`define LDR_BIT_SEL 1
`define LDR_BIT_EN 0
`define LDR_CLASS_HI 5
`define LDR_CLASS_LO 4
`define LDR_SLOT_HI 3
`define LDR_SLOT_LO 0
`define LDR_SLOT_EXCLUDED 4'hf
`define LDR_VOUT_MAX_CODE 5'h1a
`define LDR_MV_BASE 11'h3e8
`define LDR_MV_STEP 11'h019
`define LDR_CLASS_A 2'h0
`define LDR_CLASS_U 2'h1
`define LDR_CLASS_S 2'h2
`define LDR_CLASS_SX 2'h3
`endif

// file: verilog/ldr_rail_decode.v
`timescale 1ns/1ps
`include "ldr_defs.vh"
module ldr_rail_decode (
  // Register contents
  input wire [7:0] ctl,
  input wire [7:0] seq,
  input wire [7:0] vout,
  // Sequencer
  input wire sleep_state_line,
  // Decoded
  output wire rail_on,
  output wire pass_switch,
  output wire [10:0] target_mv,
  output wire [1:0] rail_class,
  output wire [3:0] power_up_slot,
  output wire slot_excluded
);
  wire [4:0] code;
  assign code = vout[4:0];
  assign rail_on = ctl[`LDR_BIT_SEL] ? ctl[`LDR_BIT_EN] : sleep_state_line;
  assign pass_switch = code > `LDR_VOUT_MAX_CODE;
  // Pass-switch codes report the top regulated target
  assign target_mv = `LDR_MV_BASE + `LDR_MV_STEP * (pass_switch ? {6'h00, `LDR_VOUT_MAX_CODE} : {6'h00, code});
  assign rail_class = seq[`LDR_CLASS_HI:`LDR_CLASS_LO];
  assign power_up_slot = seq[`LDR_SLOT_HI:`LDR_SLOT_LO];
  assign slot_excluded = power_up_slot == `LDR_SLOT_EXCLUDED;
endmodule

// file: verilog/ldr_rail_regs.v
`timescale 1ns/1ps
`include "ldr_defs.vh"
// Operation
// - With source select clear, each rail follows its sleep state line and the enable bit is ignored.
// - With source select set, each rail follows its manual enable bit.
// - Voltage code 0 means 1000 mV and each step adds 25 mV.
// - Code 26 is the highest regulated code, 1650 mV.
// - Codes 27 and above select pass-switch operation.
// - Rail class bits 5:4 decode as A, U, S, SX.
// - Slot bits 3:0 pick group 0 to 14, and 15 excludes the rail from sequencing.
// - Voltage and sequencing registers load from OTP at power-up and stay writable.
module ldr_rail_regs (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Register port from the I2C slave
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output wire reg_hit,
  // OTP preload values, valid while otp_load is high
  input wire otp_load,
  input wire [23:0] otp_vout,
  input wire [23:0] otp_seq,
  // Sequencer sleep lines, one per rail
  input wire [2:0] sleep_state_line,
  // Rail outputs
  output wire [2:0] rail_on,
  output wire [2:0] pass_switch,
  output wire [32:0] target_mv,
  output wire [5:0] rail_class,
  output wire [11:0] power_up_slot,
  output wire [2:0] slot_excluded
);
  reg [7:0] ctl [0:2];
  reg [7:0] seq [0:2];
  reg [7:0] vout [0:2];
  integer i;

  function [1:0] ldr_index;
    input [7:0] a;
    input [7:0] a0;
    input [7:0] a1;
    begin
      ldr_index = (a == a0) ? 2'h0 : (a == a1) ? 2'h1 : 2'h2;
    end
  endfunction

  function ldr_match;
    input [7:0] a;
    input [7:0] a0;
    input [7:0] a1;
    input [7:0] a2;
    begin
      ldr_match = (a == a0) | (a == a1) | (a == a2);
    end
  endfunction

  wire hit_ctl;
  wire hit_seq;
  wire hit_vout;
  wire [1:0] idx_ctl;
  wire [1:0] idx_seq;
  wire [1:0] idx_vout;
  assign hit_ctl = ldr_match(reg_addr, `LDR_ADDR_CTL0, `LDR_ADDR_CTL1, `LDR_ADDR_CTL2);
  assign hit_seq = ldr_match(reg_addr, `LDR_ADDR_SEQ0, `LDR_ADDR_SEQ1, `LDR_ADDR_SEQ2);
  assign hit_vout = ldr_match(reg_addr, `LDR_ADDR_VOUT0, `LDR_ADDR_VOUT1, `LDR_ADDR_VOUT2);
  assign idx_ctl = ldr_index(reg_addr, `LDR_ADDR_CTL0, `LDR_ADDR_CTL1);
  assign idx_seq = ldr_index(reg_addr, `LDR_ADDR_SEQ0, `LDR_ADDR_SEQ1);
  assign idx_vout = ldr_index(reg_addr, `LDR_ADDR_VOUT0, `LDR_ADDR_VOUT1);
  assign reg_hit = hit_ctl | hit_seq | hit_vout;

  // Control registers reset to constants; OTP fields load while otp_load holds
  always @(posedge core_clk) begin
    if (sys_rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        ctl[i] <= `LDR_CTL_RESET;
      end
    end else if (reg_wr && hit_ctl) begin
      ctl[idx_ctl] <= reg_wdata & `LDR_CTL_MASK;
    end
  end

  // OTP load takes priority so a stray write cannot corrupt the preload
  always @(posedge core_clk) begin
    if (sys_rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        seq[i] <= 8'h00;
        vout[i] <= 8'h00;
      end
    end else if (otp_load) begin
      for (i = 0; i < 3; i = i + 1) begin
        seq[i] <= otp_seq[i*8 +: 8] & `LDR_SEQ_MASK;
        vout[i] <= otp_vout[i*8 +: 8] & `LDR_VOUT_MASK;
      end
    end else if (reg_wr) begin
      if (hit_seq) begin
        seq[idx_seq] <= reg_wdata & `LDR_SEQ_MASK;
      end
      if (hit_vout) begin
        vout[idx_vout] <= reg_wdata & `LDR_VOUT_MASK;
      end
    end
  end

  // Unmapped addresses read zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (hit_ctl) begin
      reg_rdata <= ctl[idx_ctl];
    end else if (hit_seq) begin
      reg_rdata <= seq[idx_seq];
    end else if (hit_vout) begin
      reg_rdata <= vout[idx_vout];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : rail
      ldr_rail_decode u_dec (
        .ctl(ctl[g]),
        .seq(seq[g]),
        .vout(vout[g]),
        .sleep_state_line(sleep_state_line[g]),
        .rail_on(rail_on[g]),
        .pass_switch(pass_switch[g]),
        .target_mv(target_mv[g*11 +: 11]),
        .rail_class(rail_class[g*2 +: 2]),
        .power_up_slot(power_up_slot[g*4 +: 4]),
        .slot_excluded(slot_excluded[g])
      );
    end
  endgenerate
endmodule

// file: tb/ldr_rail_regs_asserts.sv
`timescale 1ns/1ps
module ldr_rail_regs_asserts (
  input wire core_clk, input wire sys_rst,
  input wire [7:0] reg_addr, input wire reg_wr, input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata, input wire reg_hit, input wire otp_load, input wire [23:0] otp_seq,
  input wire [2:0] sleep_state_line, input wire [2:0] rail_on, input wire [2:0] pass_switch,
  input wire [32:0] target_mv, input wire [5:0] rail_class, input wire [11:0] power_up_slot,
  input wire [2:0] slot_excluded
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_w(a);
    reg_wr && !otp_load && reg_addr == a;
  endsequence
  property p_man; s_w(8'h65) ##0 reg_wdata[1] |=> rail_on[0] == $past(reg_wdata[0]); endproperty
  a_man: assert property (p_man) else $error("manual enable ignored");
  property p_slp; s_w(8'h65) ##0 !reg_wdata[1] |=> rail_on[0] == sleep_state_line[0]; endproperty
  a_slp: assert property (p_slp) else $error("sleep line ignored");
  property p_mv; s_w(8'h68) ##0 reg_wdata[4:0] < 27 |=> target_mv[10:0] == 1000 + 25 * $past(reg_wdata[4:0]); endproperty
  a_mv: assert property (p_mv) else $error("target voltage wrong");
  property p_top; !pass_switch[0] |-> target_mv[10:0] <= 1650; endproperty
  a_top: assert property (p_top) else $error("target above top");
  property p_pass; s_w(8'h68) ##0 reg_wdata[4:0] > 26 |=> pass_switch[0]; endproperty
  a_pass: assert property (p_pass) else $error("pass switch missing");
  property p_cls; s_w(8'hed) |=> rail_class[1:0] == $past(reg_wdata[5:4]); endproperty
  a_cls: assert property (p_cls) else $error("rail class wrong");
  property p_slot; slot_excluded[0] == (&power_up_slot[3:0]); endproperty
  a_slot: assert property (p_slot) else $error("exclusion wrong");
  property p_otp; otp_load |=> {rail_class[1:0], power_up_slot[3:0]} == $past(otp_seq[5:0]); endproperty
  a_otp: assert property (p_otp) else $error("preload wrong");
  property p_rsv; !reg_hit |=> reg_rdata == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("unmapped read not zero");
endmodule
bind ldr_rail_regs ldr_rail_regs_asserts u_chk(.*);

// file: tb/ldr_host.sv
`timescale 1ns/1ps
module ldr_host (
  input wire core_clk,
  input wire [7:0] reg_rdata,
  output reg [7:0] reg_addr,
  output reg reg_wr,
  output reg [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // Data is scrambled after the write so stale values never look valid
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      @(posedge core_clk);
      #1 d = reg_rdata;
    end
  endtask
endmodule

// file: tb/ldr_rail_regs_tb.sv
`timescale 1ns/1ps
module ldr_rail_regs_tb;
  reg core_clk = 0, sys_rst = 1, otp_load = 0;
  reg [23:0] otp_vout = 0, otp_seq = 0;
  reg [2:0] sleep_state_line = 0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_hit;
  wire [2:0] rail_on, pass_switch, slot_excluded;
  wire [32:0] target_mv;
  wire [5:0] rail_class;
  wire [11:0] power_up_slot;
  integer fails = 0, tests_run = 0, seed = 84422, i, n, c[3], s[3], v[3];
  reg [7:0] rd;
  reg [7:0] al[10] = '{8'h65, 8'h61, 8'h66, 8'hed, 8'hee, 8'hef, 8'h68, 8'h69, 8'h6a, 8'h62};
  always #10 core_clk = ~core_clk;
  ldr_host u_host(.*);
  ldr_rail_regs u_dut(.*);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cmp;
    begin
      #1;
      for (i = 0; i < 3; i = i + 1) begin
        chk(rail_on[i], c[i][1] ? c[i][0] : sleep_state_line[i]);
        chk(pass_switch[i], v[i] > 26);
        chk(target_mv[11*i+:11], v[i] > 26 ? 1650 : 1000 + 25 * v[i]);
        chk(rail_class[2*i+:2], s[i][5:4]);
        chk({slot_excluded[i], power_up_slot[4*i+:4]}, {s[i][3:0] == 15, s[i][3:0]});
      end
    end
  endtask
  task acc(input integer k, input [7:0] d);
    begin
      u_host.wr(al[k], d);
      if (k < 3) c[k] = d & 3; else if (k < 6) s[k-3] = d & 63; else if (k < 9) v[k-6] = d & 31;
      u_host.rd(al[k], rd);
      chk(rd, k < 3 ? c[k] : k < 6 ? s[k-3] : k < 9 ? v[k-6] : 0);
      chk(reg_hit, k < 9);
      cmp;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (2) begin
      for (i = 0; i < 3; i = i + 1) begin c[i] = 0; s[i] = 0; v[i] = 0; end
      repeat (4) @(posedge core_clk);
      sys_rst <= 0;
      cmp;
      @(posedge core_clk);
      otp_load <= 1;
      otp_vout <= $random(seed);
      otp_seq <= $random(seed);
      @(posedge core_clk);
      otp_load <= 0;
      for (i = 0; i < 3; i = i + 1) begin s[i] = otp_seq[8*i+:8] & 63; v[i] = otp_vout[8*i+:8] & 31; end
      cmp;
      for (n = 0; n < 4; n = n + 1) acc(3, n * 16 + 8'hce + n % 2);
      acc(6, 8'hfa);
      acc(6, 8'h1b);
      repeat (60) begin
        @(posedge core_clk) sleep_state_line <= $random(seed);
        acc($unsigned($random(seed)) % 10, $random(seed));
      end
      @(posedge core_clk) sys_rst <= 1;
    end
    give_verdict;
  end
endmodule
